// *** rtl/pibc_pkg.sv ***
// Purpose: Shared constants and types for the PCI-to-ISA bridge control block
// Assumes: 8-bit configuration byte port, PCI clock domain only
// Notes:   Sample-point delays count PCI clocks from the address phase
package pibc_pkg;

  // ==========================================================
  // Configuration space
  localparam logic [7:0] PIBC_CTL_OFFSET = 8'h40;
  localparam logic [7:0] PIBC_CTL_RESET  = 8'h20;
  localparam logic [7:0] PIBC_CTL_WMASK  = 8'h7f;

  // ==========================================================
  // Control register layout, bit 7 reserved
  typedef struct packed {
    logic       reserved;
    logic       page_alias_ctl;
    logic       int_ack_enable;
    logic [1:0] subtractive_sample_point;
    logic       posted_write_buf_enable;
    logic       isa_master_linebuf_cfg;
    logic       dma_linebuf_cfg;
  } pibc_ctl_t;

  typedef enum logic [1:0] {
    PIBC_SP_SLOW     = 2'h0,
    PIBC_SP_TYPICAL  = 2'h1,
    PIBC_SP_FAST     = 2'h2,
    PIBC_SP_RESERVED = 2'h3
  } pibc_sp_t;

  // Clock after the address phase at which DEVSEL# is sampled
  localparam logic [2:0] PIBC_SP_FAST_CLK    = 3'h2;
  localparam logic [2:0] PIBC_SP_TYPICAL_CLK = 3'h3;
  localparam logic [2:0] PIBC_SP_SLOW_CLK    = 3'h4;

  // ==========================================================
  // PCI commands and I/O decode
  localparam logic [3:0] PIBC_CMD_INTA   = 4'h0;
  localparam logic [3:0] PIBC_CMD_IORD   = 4'h2;
  localparam logic [3:0] PIBC_CMD_IOWR   = 4'h3;
  localparam logic [3:0] PIBC_CMD_MEMWR  = 4'h7;

  localparam logic [15:0] PIBC_PAGE_BASE  = 16'h0080;
  localparam logic [15:0] PIBC_PAGE_MASK  = 16'hfff0;
  localparam logic [15:0] PIBC_ALIAS_MASK = 16'hffe0;
  localparam logic [15:0] PIBC_ALIAS_BASE = 16'h0090;
  localparam logic [15:0] PIBC_PORT92     = 16'h0092;
  localparam logic [15:0] PIBC_INTC_MASK  = 16'hfffe;
  localparam logic [15:0] PIBC_INTC1_BASE = 16'h0020;
  localparam logic [15:0] PIBC_INTC2_BASE = 16'h00a0;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [15:0] addr;
  } pibc_cyc_t;

  typedef struct packed {
    logic page_reg;
    logic port92;
    logic intc;
    logic int_ack;
    logic fwd_isa;
    logic posted;
  } pibc_hit_t;

endpackage

// *** rtl/pibc_bridge_ctl.sv ***
// Purpose: Control byte of a PCI-to-ISA bridge and the target-side decode it steers
// Assumes: All inputs are synchronous to ref_clk_i (the PCI clock), so none is resynchronised
// Notes:   One cycle at a time; a new start aborts a pending subtractive wait

// Notes on behaviour
// [R1] Control register is eight bits; top bit always reads zero.
// [R2] Alias bit clear: ignore address bit 4, 90h-9Fh hit the page registers.
// [R3] Alias bit set: claim only 80h-8Fh, forward 90h-9Fh to ISA.
// [R4] Port 92h is always fully decoded as its own register.
// [R5] Interrupt-acknowledge disabled: ignore INTA, still serve controller registers and polling.
// [R6] Interrupt-acknowledge enabled: respond to INTA; set after reset value 20h.
// [R7] Sample field picks DEVSEL# sample clock; still inactive means subtractive claim to ISA.
// [R8] Sample codes: 00 slow, 01 typical, 10 fast, 11 reserved.
// [R9] Software should match the sample point to the slowest target present.
// [R10] Posted write buffer off when bit clear (reset), on when set.
// [R11] ISA-master line buffer: single transaction when clear, 8-byte when set.
// [R12] DMA line buffer: single transaction when clear, 8-byte when set.
// [R13] Reserved sample code behaves as the slow sample point.
module pibc_bridge_ctl (
  input  wire logic                 ref_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 cfg_wr_i,
  input  wire logic                 cfg_rd_i,
  input  wire logic [7:0]           cfg_addr_i,
  input  wire logic [7:0]           cfg_wdata_i,
  input  wire logic                 cyc_start_i,
  input  wire pibc_pkg::pibc_cyc_t  cyc_i,
  input  wire logic                 devsel_n_i,
  input  wire logic                 lb_xfer_dma_i,
  output logic [7:0]                cfg_rdata_o,
  output logic                      cfg_ack_o,
  output pibc_pkg::pibc_hit_t       hit_o,
  output logic                      subtractive_claim_o,
  output logic                      posted_write_buf_en_o,
  output logic                      linebuf_8byte_o
);

  // ==========================================================
  // Control register
  pibc_pkg::pibc_ctl_t ctl_r;
  logic [7:0]          cfg_rdata_r;
  logic                cfg_ack_r;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_r <= pibc_pkg::PIBC_CTL_RESET; // see [R6]
    end else if (cfg_wr_i && cfg_addr_i == pibc_pkg::PIBC_CTL_OFFSET) begin
      ctl_r <= cfg_wdata_i & pibc_pkg::PIBC_CTL_WMASK; // see [R1]
    end
  end

  // Reads of other offsets return zero; they belong to other registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_rdata_r <= 8'h00;
    end else if (cfg_rd_i && cfg_addr_i == pibc_pkg::PIBC_CTL_OFFSET) begin
      cfg_rdata_r <= ctl_r & pibc_pkg::PIBC_CTL_WMASK; // see [R1]
    end else begin
      cfg_rdata_r <= 8'h00;
    end
  end

  // Every access is acknowledged, mapped or not, so the host never stalls
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_ack_r <= 1'b0;
    end else begin
      cfg_ack_r <= cfg_wr_i | cfg_rd_i;
    end
  end

  assign cfg_rdata_o = cfg_rdata_r;
  assign cfg_ack_o   = cfg_ack_r;

  // ==========================================================
  // Positive decode of the address phase
  pibc_pkg::pibc_hit_t hit_nxt;
  pibc_pkg::pibc_hit_t hit_r;
  logic                is_io;
  logic                in_page;
  logic                in_alias;
  logic                is_p92;

  always_comb begin
    is_io    = (cyc_i.cmd == pibc_pkg::PIBC_CMD_IORD) || (cyc_i.cmd == pibc_pkg::PIBC_CMD_IOWR);
    in_page  = (cyc_i.addr & pibc_pkg::PIBC_PAGE_MASK) == pibc_pkg::PIBC_PAGE_BASE;
    in_alias = (cyc_i.addr & pibc_pkg::PIBC_PAGE_MASK) == pibc_pkg::PIBC_ALIAS_BASE;
    is_p92   = cyc_i.addr == pibc_pkg::PIBC_PORT92;
    hit_nxt  = '0;
    if (cyc_start_i) begin
      hit_nxt.port92 = is_io && is_p92; // see [R4]
      if (ctl_r.page_alias_ctl) begin
        hit_nxt.page_reg = is_io && in_page; // see [R3]
        hit_nxt.fwd_isa  = is_io && in_alias && !is_p92; // see [R3]
      end else begin
        // Address bit 4 dropped from the compare
        hit_nxt.page_reg = is_io && !is_p92 &&
                           ((cyc_i.addr & pibc_pkg::PIBC_ALIAS_MASK) == pibc_pkg::PIBC_PAGE_BASE); // see [R2]
      end
      // Controller registers stay reachable so polling still works
      hit_nxt.intc = is_io &&
                     (((cyc_i.addr & pibc_pkg::PIBC_INTC_MASK) == pibc_pkg::PIBC_INTC1_BASE) ||
                      ((cyc_i.addr & pibc_pkg::PIBC_INTC_MASK) == pibc_pkg::PIBC_INTC2_BASE)); // see [R5]
      hit_nxt.int_ack = ctl_r.int_ack_enable && (cyc_i.cmd == pibc_pkg::PIBC_CMD_INTA); // see [R5] [R6]
      hit_nxt.posted  = ctl_r.posted_write_buf_enable && (cyc_i.cmd == pibc_pkg::PIBC_CMD_MEMWR); // see [R10]
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hit_r <= '0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  assign hit_o = hit_r;

  // ==========================================================
  // Subtractive decode: wait to the sample clock, then claim if nobody did
  typedef enum logic {PIBC_ST_IDLE, PIBC_ST_WAIT} pibc_st_t;

  pibc_st_t   st_r;
  logic [2:0] cnt_r;
  logic [2:0] sample_clk_r;
  logic       claim_r;
  logic [2:0] sample_clk;

  always_comb begin
    unique case (pibc_pkg::pibc_sp_t'(ctl_r.subtractive_sample_point)) // see [R8]
      pibc_pkg::PIBC_SP_FAST:    sample_clk = pibc_pkg::PIBC_SP_FAST_CLK;
      pibc_pkg::PIBC_SP_TYPICAL: sample_clk = pibc_pkg::PIBC_SP_TYPICAL_CLK;
      // Reserved falls back to slow so a slow target is never double-claimed
      pibc_pkg::PIBC_SP_SLOW,
      pibc_pkg::PIBC_SP_RESERVED: sample_clk = pibc_pkg::PIBC_SP_SLOW_CLK; // see [R13]
    endcase
  end

  // Our own positive claims never go subtractive; INTA disabled is left unanswered too
  logic own_claim;

  always_comb begin
    own_claim = hit_nxt.page_reg | hit_nxt.port92 | hit_nxt.intc | hit_nxt.int_ack;
    own_claim = own_claim | hit_nxt.fwd_isa; // see [R3]
    if (cyc_i.cmd == pibc_pkg::PIBC_CMD_INTA) begin
      own_claim = 1'b1; // see [R5]
    end
  end

  // A start always restarts, so a late DEVSEL# of an older cycle is never counted
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= PIBC_ST_IDLE;
    end else if (cyc_start_i) begin
      st_r <= own_claim ? PIBC_ST_IDLE : PIBC_ST_WAIT;
    end else begin
      unique case (st_r)
        PIBC_ST_IDLE: st_r <= PIBC_ST_IDLE;
        PIBC_ST_WAIT: begin
          if (!devsel_n_i || cnt_r == sample_clk_r) begin
            st_r <= PIBC_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Clocks since the address phase; parked at zero while idle
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 3'h0;
    end else if (cyc_start_i) begin
      cnt_r <= 3'h1;
    end else if (st_r == PIBC_ST_WAIT && devsel_n_i && cnt_r != sample_clk_r) begin
      cnt_r <= cnt_r + 3'h1;
    end else if (st_r == PIBC_ST_IDLE) begin
      cnt_r <= 3'h0;
    end
  end

  // Latched per cycle so a config write during a wait cannot move the point
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample_clk_r <= pibc_pkg::PIBC_SP_SLOW_CLK;
    end else if (cyc_start_i) begin
      sample_clk_r <= sample_clk; // see [R7]
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      claim_r <= 1'b0;
    end else begin
      claim_r <= !cyc_start_i && st_r == PIBC_ST_WAIT && cnt_r == sample_clk_r && devsel_n_i; // see [R7]
    end
  end

  assign subtractive_claim_o = claim_r;

  // ==========================================================
  // Buffer controls
  logic pwb_r;
  logic lb8_r;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwb_r <= 1'b0;
    end else begin
      pwb_r <= ctl_r.posted_write_buf_enable; // see [R10]
    end
  end

  // Mode follows the transfer type every clock; nothing is held across transfers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lb8_r <= 1'b0;
    end else begin
      lb8_r <= lb_xfer_dma_i ? ctl_r.dma_linebuf_cfg        // see [R12]
                             : ctl_r.isa_master_linebuf_cfg; // see [R11]
    end
  end

  assign posted_write_buf_en_o = pwb_r;
  assign linebuf_8byte_o       = lb8_r;

endmodule

// *** sim/pibc_bridge_ctl_chk.sv ***
// Purpose: Port checks for the bridge control block
// Assumes: Control byte shadowed from config writes
// Notes:   Port 300h is never claimed by the positive decode; claim checks need DEVSEL# to stay high
module pibc_bridge_ctl_chk (
  input wire logic                 ref_clk_i,
  input wire logic                 resetn_i,
  input wire logic                 cfg_wr_i,
  input wire logic                 cfg_rd_i,
  input wire logic [7:0]           cfg_addr_i,
  input wire logic [7:0]           cfg_wdata_i,
  input wire logic                 cyc_start_i,
  input wire pibc_pkg::pibc_cyc_t  cyc_i,
  input wire logic                 devsel_n_i,
  input wire logic                 lb_xfer_dma_i,
  input wire logic [7:0]           cfg_rdata_o,
  input wire logic                 cfg_ack_o,
  input wire pibc_pkg::pibc_hit_t  hit_o,
  input wire logic                 subtractive_claim_o,
  input wire logic                 posted_write_buf_en_o,
  input wire logic                 linebuf_8byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctl_r;
  logic       io_c;
  assign io_c = cyc_start_i && cyc_i.cmd == pibc_pkg::PIBC_CMD_IORD;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_r <= pibc_pkg::PIBC_CTL_RESET;
    end else if (cfg_wr_i && cfg_addr_i == pibc_pkg::PIBC_CTL_OFFSET) begin
      ctl_r <= cfg_wdata_i & pibc_pkg::PIBC_CTL_WMASK;
    end
  end
  // ========
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  a_read_top_bit: assert property (
    cfg_rd_i |=> cfg_ack_o && !cfg_rdata_o[7]) else $error("read");
  a_alias_fwd: assert property (
    io_c && cyc_i.addr == 16'h95 && ctl_r[6] |=> hit_o.fwd_isa && !hit_o.page_reg) else $error("alias");
  a_port92_own: assert property (
    io_c && cyc_i.addr == 16'h92 |=> hit_o.port92 && !hit_o.fwd_isa) else $error("92");
  a_inta_off: assert property (
    cyc_start_i && cyc_i.cmd == pibc_pkg::PIBC_CMD_INTA && !ctl_r[5] |=> hit_o == '0) else $error("inta");
  a_posted_level: assert property (
    posted_write_buf_en_o == $past(ctl_r[2])) else $error("posted");
  a_linebuf_sel: assert property (
    linebuf_8byte_o == $past(lb_xfer_dma_i ? ctl_r[0] : ctl_r[1])) else $error("linebuf");
  a_claim_fast: assert property (
    io_c && cyc_i.addr == 16'h300 && ctl_r[4:3] == 2'h2 ##1 (devsel_n_i && !cyc_start_i)[*2]
    |=> subtractive_claim_o) else $error("fast");
  a_claim_typical: assert property (
    io_c && cyc_i.addr == 16'h300 && ctl_r[4:3] == 2'h1 ##1 (devsel_n_i && !cyc_start_i)[*3]
    |=> subtractive_claim_o) else $error("typical");
  a_claim_slow: assert property (
    io_c && cyc_i.addr == 16'h300 && ctl_r[4] == ctl_r[3] ##1 (devsel_n_i && !cyc_start_i)[*4]
    |=> subtractive_claim_o) else $error("slow");
endmodule
bind pibc_bridge_ctl pibc_bridge_ctl_chk u_chk (.*);

// *** sim/pibc_pci_target_model.sv ***
// Purpose: PCI target claiming a cycle at a chosen clock
// Assumes: Claim clock 0 means never claim
// Notes:   Released line is pulled up high
module pibc_pci_target_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [2:0] claim_clk_i,
  output logic            devsel_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r = 3'h0;
  initial devsel_n_o = 1'b1;
  always @(posedge clk_i) cnt_r <= start_i ? 3'h1 : cnt_r + 3'((cnt_r != 3'h0) && (cnt_r != 3'h7));
  always @(negedge clk_i) devsel_n_o <= !(claim_clk_i != 3'h0 && cnt_r >= claim_clk_i && cnt_r != 3'h7);
endmodule

// *** sim/pibc_bridge_ctl_tb.sv ***
// Purpose: Self-checking bench for the bridge control block
// Assumes: Inputs change on the falling edge
// Notes:   Port 300h left unclaimed by the bridge's positive decode; the target model claims it in sample runs 4 to 7
module pibc_bridge_ctl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] ctl; logic [3:0] cmd; logic [15:0] addr; logic [5:0] hit;} pibc_row_t;
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, cyc_start_i = 1'b0;
  logic lb_xfer_dma_i = 1'b0, devsel_n_i, cfg_ack_o, subtractive_claim_o, posted_write_buf_en_o, linebuf_8byte_o;
  logic [7:0] cfg_addr_i = 8'h0, cfg_wdata_i = 8'h0, cfg_rdata_o, rdata = 8'h0;
  logic [2:0] tgt = 3'h0, spc [4] = '{3'h4, 3'h3, 3'h2, 3'h4};
  pibc_pkg::pibc_cyc_t cyc_i = '0;
  pibc_pkg::pibc_hit_t hit_o;
  int fails = 0, compares = 0, cycles = 0, at;
  pibc_row_t rows [8] = '{'{8'ha0, 4'h2, 16'h95, 6'h20}, '{8'he3, 4'h2, 16'h95, 6'h02},
    '{8'h61, 4'h3, 16'h92, 6'h10}, '{8'h22, 4'h2, 16'h92, 6'h10}, '{8'h00, 4'h0, 16'h0, 6'h00},
    '{8'h02, 4'h2, 16'h21, 6'h08}, '{8'ha5, 4'h0, 16'h0, 6'h04}, '{8'h24, 4'h7, 16'h1000, 6'h01}};
  pibc_bridge_ctl u_dut (.*);
  pibc_pci_target_model u_tgt (.clk_i(ref_clk_i), .start_i(cyc_start_i), .claim_clk_i(tgt), .devsel_n_o(devsel_n_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [7:0] d);
    {cfg_wr_i, cfg_rd_i, cfg_addr_i, cfg_wdata_i} = {wr, !wr, a, d};
    @(negedge ref_clk_i);
    rdata = cfg_rdata_o;
    chk({7'h0, cfg_ack_o}, 8'h1);
    {cfg_wr_i, cfg_rd_i} = 2'h0;
    @(negedge ref_clk_i);
  endtask
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (++cycles == 1000) begin
    fails++;
    wrap_up;
  end
  initial begin
    repeat (10) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    foreach (rows[i]) begin
      lb_xfer_dma_i = i[0];
      cfg(1'b1, 8'h40, rows[i].ctl);
      cfg(1'b0, 8'h40, 8'h0);
      chk(rdata, rows[i].ctl & 8'h7f);
      chk({7'h0, posted_write_buf_en_o}, {7'h0, rows[i].ctl[2]});
      chk({7'h0, linebuf_8byte_o}, {7'h0, rows[i].ctl[!i[0]]});
      {cyc_start_i, cyc_i} = {1'b1, rows[i].cmd, rows[i].addr};
      @(negedge ref_clk_i) cyc_start_i = 1'b0;
      chk({2'h0, hit_o}, {2'h0, rows[i].hit});
    end
    for (int s = 0; s < 8; s++) begin
      tgt = s[2] ? spc[s[1:0]] : 3'h0;
      cfg(1'b1, 8'h40, {3'h1, s[1:0], 3'h0});
      at = 0;
      {cyc_start_i, cyc_i} = {1'b1, 4'h2, 16'h300};
      for (int k = 0; k < 9; k++) begin
        @(negedge ref_clk_i) cyc_start_i = 1'b0;
        if (subtractive_claim_o === 1'b1 && at == 0) at = k;
      end
      chk(8'(at), s[2] ? 8'h0 : {5'h0, spc[s[1:0]]});
    end
    cfg(1'b1, 8'h41, 8'hff);
    cfg(1'b0, 8'h41, 8'h0);
    chk(rdata, 8'h0);
    cfg(1'b0, 8'h40, 8'h0);
    chk(rdata, 8'h38);
    resetn_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    cfg(1'b0, 8'h40, 8'h0);
    chk(rdata, 8'h20);
    chk({6'h0, posted_write_buf_en_o, linebuf_8byte_o}, 8'h0);
    wrap_up;
  end
endmodule
